// ==== rtl/gpio_port_pkg.sv ====
// Package: register map, reset values and modes of the shared GPIO port
package gpio_port_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned SYNC_STAGES = 2;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [PORT_W-1:0] port_t;

  // ----------------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ----------------------------------------------------------------------
  localparam addr_t OFS_PORT_THREE_DIRECTION   = 5'h00;
  localparam addr_t OFS_PORT_THREE_LATCH       = 5'h04;
  localparam addr_t OFS_PORT_THREE_PULLUP      = 5'h08;
  localparam addr_t OFS_PORT_FOUR_DIRECTION    = 5'h0C;
  localparam addr_t OFS_HOST_IFACE_CONTROL     = 5'h10;
  localparam addr_t OFS_PORT_THREE_STATUS      = 5'h14;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam port_t RST_PORT_THREE_DIRECTION   = 8'h00;
  localparam port_t RST_PORT_THREE_LATCH       = 8'h00;
  localparam port_t RST_PORT_THREE_PULLUP      = 8'h00;
  localparam port_t RST_PORT_FOUR_DIRECTION    = 8'h00;
  localparam logic [3:0] RST_HOST_IFACE_CONTROL = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO     = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Host interface control field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_ALT_HOST_BIT   = 0;
  localparam int unsigned CTL_LPC_FIRST_BIT  = 1;
  localparam int unsigned CTL_LPC_SECOND_BIT = 2;
  localparam int unsigned CTL_LPC_THIRD_BIT  = 3;

  // ----------------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------------
  localparam int unsigned STS_LPC_SEL_LSB    = 0;
  localparam int unsigned STS_PULLUP_LSB     = 8;

  // ----------------------------------------------------------------------
  // Port four peripheral pin positions
  // ----------------------------------------------------------------------
  localparam int unsigned P4_PWM_LSB         = 6;
  localparam int unsigned P4_PWM_W           = 2;
  localparam int unsigned P4_PERIPH_W        = 6;

  // ----------------------------------------------------------------------
  // Bus handshake phase
  // ----------------------------------------------------------------------
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_phase_e;

endpackage : gpio_port_pkg

// ==== rtl/port_pin_sync.sv ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps

module port_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // Per-bit double flop
  // ----------------------------------------------------------------------
  // First stage feeds only the second stage, nothing else looks at it
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg   <= async_in[gi];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[gi] = stable_reg;
    end
  endgenerate

endmodule : port_pin_sync

// ==== rtl/lpc_shared_gpio_port.sv ====
// Shared GPIO port with LPC pin handover, pull-ups and second-port direction
`timescale 1ns/1ps
// Summary of operation
// RL1: Reading port with direction 1 returns output latch bit, not pin.
// RL2: Reading port with direction 0 returns synchronised pin level.
// RL3: Output latch is eight read/write bits, cleared at reset.
// RL4: Pull-up on when its control bit is 1 and pin is input.
// RL5: Pull-up control is an eight-bit read/write register, reset zero.
// RL6: Pull-ups stay off whenever any host interface is enabled.
// RL7: Pull-ups forced off during reset and hardware standby.
// RL8: Otherwise pull-up on only for input, direction 0, control 1.
// RL9: All host enables zero: direction 0 input, direction 1 output.
// RL10: Any LPC enable, alternate off, direction 0: pin goes to LPC.
// RL11: LPC bits: 7 SERIRQ, 6 LCLK, 5 LRESET#, 4 LFRAME#, 3..0 LAD.
// RL12: Software never programs other enable and direction combinations.
// RL13: Second port direction is write-only, reset zero, 1 output.
// RL14: Software standby resets PWM; timers, I2C and registers decide pins.
// RL15: First port direction is write-only, reset zero, 1 output.
// RL16: LPC-owned pins take drive and enable from host logic.
// RL17: Writes land on the second edge after the request; pin inputs synchronised before reading.

module lpc_shared_gpio_port (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  // Avalon-MM slave
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [gpio_port_pkg::DATA_W-1:0]  avs_readdata,
  output logic                                   avs_waitrequest,
  // Chip power state
  input  wire logic                              hw_standby,
  input  wire logic                              sw_standby,
  // First port pins
  input  wire logic [gpio_port_pkg::PORT_W-1:0]  port_three_pin_in,
  output logic      [gpio_port_pkg::PORT_W-1:0]  port_three_pin_out,
  output logic      [gpio_port_pkg::PORT_W-1:0]  port_three_pin_oe,
  output logic      [gpio_port_pkg::PORT_W-1:0]  port_three_pullup_en,
  // Host interface (LPC) side of the first port
  input  wire logic [gpio_port_pkg::PORT_W-1:0]  lpc_pin_out,
  input  wire logic [gpio_port_pkg::PORT_W-1:0]  lpc_pin_oe,
  output logic      [gpio_port_pkg::PORT_W-1:0]  lpc_pin_in,
  output logic      [gpio_port_pkg::PORT_W-1:0]  lpc_pin_sel,
  output logic      [2:0]                        lpc_channel_enable,
  output logic                                   alt_host_interface_enable,
  // Second port
  input  wire logic [gpio_port_pkg::P4_PWM_W-1:0]    pwm_pin_oe,
  input  wire logic [gpio_port_pkg::P4_PERIPH_W-1:0] periph_pin_oe,
  output logic      [gpio_port_pkg::PORT_W-1:0]  port_four_direction,
  output logic      [gpio_port_pkg::PORT_W-1:0]  port_four_pin_oe,
  output logic                                   pwm_unit_reset
);

  import gpio_port_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  port_t              port_three_direction_reg;
  port_t              port_three_output_latch_reg;
  port_t              port_three_pullup_control_reg;
  port_t              port_four_direction_reg;
  logic [3:0]         host_ctl_reg;
  bus_phase_e         phase_reg;
  bus_phase_e         phase_next;
  logic [DATA_W-1:0]  readdata_reg;
  logic [DATA_W-1:0]  readdata_next;
  port_t              pin_sync;
  port_t              port_read_value;
  port_t              lpc_sel_next;
  port_t              pullup_next;
  port_t              pin_out_next;
  port_t              pin_oe_next;
  port_t              p4_oe_next;
  port_t              lpc_sel_reg;
  port_t              pullup_reg;
  port_t              pin_out_reg;
  port_t              pin_oe_reg;
  port_t              lpc_in_reg;
  port_t              p4_oe_reg;
  logic               pwm_reset_reg;
  logic               waitrequest_reg;
  logic               request;
  logic               accept;
  logic               wr_take;
  logic               lpc_any;
  logic               host_enabled;

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  port_pin_sync #(
    .WIDTH    (PORT_W)
  ) u_pin_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (port_three_pin_in),
    .sync_out (pin_sync)                               // see RL17
  );

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  // One wait cycle: the request is decoded on the first edge and answered
  // on the second, so read data and waitrequest both come from flops.
  assign request = avs_read | avs_write;
  assign accept  = request & (phase_reg == BUS_IDLE);
  assign wr_take = avs_write & (phase_reg == BUS_ANSWER)
                 & avs_byteenable[0];

  always_comb begin
    phase_next = BUS_IDLE;
    unique case (phase_reg)
      BUS_IDLE:   phase_next = request ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: phase_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase_reg       <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
    end else begin
      phase_reg       <= phase_next;
      waitrequest_reg <= (phase_next == BUS_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // First port direction
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_three_direction_reg <= RST_PORT_THREE_DIRECTION;  // see RL15
    end else if (wr_take && avs_address == OFS_PORT_THREE_DIRECTION) begin
      port_three_direction_reg <= avs_writedata[PORT_W-1:0]; // see RL17
    end
  end

  // ----------------------------------------------------------------------
  // First port output latch
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_three_output_latch_reg <= RST_PORT_THREE_LATCH;   // see RL3
    end else if (wr_take && avs_address == OFS_PORT_THREE_LATCH) begin
      port_three_output_latch_reg <= avs_writedata[PORT_W-1:0]; // see RL3
    end
  end

  // ----------------------------------------------------------------------
  // Pull-up control
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_three_pullup_control_reg <= RST_PORT_THREE_PULLUP; // see RL5
    end else if (wr_take && avs_address == OFS_PORT_THREE_PULLUP) begin
      port_three_pullup_control_reg <= avs_writedata[PORT_W-1:0]; // see RL5
    end
  end

  // ----------------------------------------------------------------------
  // Second port direction
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_four_direction_reg <= RST_PORT_FOUR_DIRECTION;    // see RL13
    end else if (wr_take && avs_address == OFS_PORT_FOUR_DIRECTION) begin
      port_four_direction_reg <= avs_writedata[PORT_W-1:0];  // see RL13
    end
  end

  // ----------------------------------------------------------------------
  // Host interface enables
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      host_ctl_reg <= RST_HOST_IFACE_CONTROL;
    end else if (wr_take && avs_address == OFS_HOST_IFACE_CONTROL) begin
      host_ctl_reg <= avs_writedata[3:0];
    end
  end

  assign lpc_any      = host_ctl_reg[CTL_LPC_FIRST_BIT]
                      | host_ctl_reg[CTL_LPC_SECOND_BIT]
                      | host_ctl_reg[CTL_LPC_THIRD_BIT];
  assign host_enabled = lpc_any | host_ctl_reg[CTL_ALT_HOST_BIT];

  // ----------------------------------------------------------------------
  // Port read value
  // ----------------------------------------------------------------------
  // Output pins read back the latch, input pins the synchronised level
  assign port_read_value = (port_three_direction_reg
                            & port_three_output_latch_reg)     // see RL1
                         | (~port_three_direction_reg
                            & pin_sync);                       // see RL2

  // ----------------------------------------------------------------------
  // Read data decode
  // ----------------------------------------------------------------------
  // Write-only registers and unmapped offsets read as zero
  always_comb begin
    readdata_next = RDATA_ZERO;
    unique case (avs_address)
      OFS_PORT_THREE_LATCH:
        readdata_next[PORT_W-1:0] = port_read_value;
      OFS_PORT_THREE_PULLUP:
        readdata_next[PORT_W-1:0] = port_three_pullup_control_reg;
      OFS_HOST_IFACE_CONTROL:
        readdata_next[3:0] = host_ctl_reg;
      OFS_PORT_THREE_STATUS: begin
        readdata_next[STS_LPC_SEL_LSB +: PORT_W] = lpc_sel_reg;
        readdata_next[STS_PULLUP_LSB +: PORT_W]  = pullup_reg;
      end
      default:
        readdata_next = RDATA_ZERO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      readdata_reg <= RDATA_ZERO;
    end else if (accept && avs_read) begin
      readdata_reg <= readdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------------
  // Combinations other than the three legal ones fall back to plain GPIO
  // behaviour by direction bit; software is expected never to use them.
  always_comb begin
    lpc_sel_next = {PORT_W{1'b0}};
    if (lpc_any && !host_ctl_reg[CTL_ALT_HOST_BIT]) begin
      lpc_sel_next = ~port_three_direction_reg;                // see RL10
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lpc_sel_reg <= {PORT_W{1'b0}};
    end else begin
      lpc_sel_reg <= lpc_sel_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // Bit order on the LPC side: 7 serirq, 6 lclk, 5 lreset_n, 4 lframe_n,
  // 3..0 lad; the mapping is one to one, bit for bit.
  always_comb begin
    pin_out_next = port_three_output_latch_reg;                // see RL9
    pin_oe_next  = port_three_direction_reg;                   // see RL9
    for (int i = 0; i < PORT_W; i++) begin
      if (lpc_sel_next[i]) begin
        pin_out_next[i] = lpc_pin_out[i];                      // see RL16
        pin_oe_next[i]  = lpc_pin_oe[i];                       // see RL11
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_out_reg <= {PORT_W{1'b0}};
      pin_oe_reg  <= {PORT_W{1'b0}};
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  // Host logic sees the synchronised pins, valid only where selected
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lpc_in_reg <= {PORT_W{1'b0}};
    end else begin
      lpc_in_reg <= pin_sync & lpc_sel_next;                   // see RL11
    end
  end

  // ----------------------------------------------------------------------
  // Pull-up control
  // ----------------------------------------------------------------------
  // Software standby keeps pull-ups under register control; only hardware
  // standby, an enabled host interface and reset force them off.
  always_comb begin
    pullup_next = port_three_pullup_control_reg
                & ~port_three_direction_reg;            // see RL4 see RL8
    if (host_enabled) begin
      pullup_next = {PORT_W{1'b0}};                            // see RL6
    end
    if (hw_standby) begin
      pullup_next = {PORT_W{1'b0}};                            // see RL7
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pullup_reg <= {PORT_W{1'b0}};                            // see RL7
    end else begin
      pullup_reg <= pullup_next;
    end
  end

  // ----------------------------------------------------------------------
  // Second port pin enables
  // ----------------------------------------------------------------------
  // PWM drive is dropped in software standby since that unit is held in
  // reset; timer and I2C enables and the direction register still count.
  always_comb begin
    p4_oe_next = port_four_direction_reg;                      // see RL13
    p4_oe_next[P4_PERIPH_W-1:0] = port_four_direction_reg[P4_PERIPH_W-1:0]
                                | periph_pin_oe;               // see RL14
    if (!sw_standby) begin
      p4_oe_next[P4_PWM_LSB +: P4_PWM_W] =
        port_four_direction_reg[P4_PWM_LSB +: P4_PWM_W] | pwm_pin_oe;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      p4_oe_reg     <= {PORT_W{1'b0}};
      pwm_reset_reg <= 1'b1;
    end else begin
      p4_oe_reg     <= p4_oe_next;
      pwm_reset_reg <= sw_standby;                             // see RL14
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign avs_readdata              = readdata_reg;
  assign avs_waitrequest           = waitrequest_reg;
  assign port_three_pin_out        = pin_out_reg;
  assign port_three_pin_oe         = pin_oe_reg;
  assign port_three_pullup_en      = pullup_reg;
  assign lpc_pin_in                = lpc_in_reg;
  assign lpc_pin_sel               = lpc_sel_reg;
  assign lpc_channel_enable        = host_ctl_reg[CTL_LPC_THIRD_BIT:
                                                  CTL_LPC_FIRST_BIT];
  assign alt_host_interface_enable = host_ctl_reg[CTL_ALT_HOST_BIT];
  assign port_four_direction       = port_four_direction_reg;
  assign port_four_pin_oe          = p4_oe_reg;
  assign pwm_unit_reset            = pwm_reset_reg;

endmodule : lpc_shared_gpio_port

// ==== dv/gpio_port_chk.sv ====
// Checker: port-level assertions for the shared GPIO port
`timescale 1ns/1ps
module gpio_port_chk (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       hw_standby,
  input wire logic       sw_standby,
  input wire logic [7:0] port_three_pin_out,
  input wire logic [7:0] port_three_pin_oe,
  input wire logic [7:0] port_three_pullup_en,
  input wire logic [7:0] lpc_pin_out,
  input wire logic [7:0] lpc_pin_oe,
  input wire logic [7:0] lpc_pin_in,
  input wire logic [7:0] lpc_pin_sel,
  input wire logic [2:0] lpc_channel_enable,
  input wire logic       alt_host_interface_enable,
  input wire logic [5:0] periph_pin_oe,
  input wire logic [7:0] port_four_direction,
  input wire logic [7:0] port_four_pin_oe,
  input wire logic       pwm_unit_reset
);
  wire host_on = (|lpc_channel_enable) | alt_host_interface_enable;
  wire lpc_on  = (|lpc_channel_enable) & ~alt_host_interface_enable;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_one_wait; s_req |=> s_one_wait; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("answer not after exactly one wait state");
  // ----------------------------------------------------------------
  // Pull-ups and pin ownership
  // ----------------------------------------------------------------
  property p_hw_off; hw_standby |=> port_three_pullup_en == 8'h00; endproperty
  a_hw_off: assert property (p_hw_off)
    else $error("pull-up on in hardware standby");
  property p_host_off;
    host_on && $past(host_on) |-> port_three_pullup_en == 8'h00;
  endproperty
  a_host_off: assert property (p_host_off)
    else $error("pull-up on with host interface enabled");
  property p_pu_input; (port_three_pullup_en & port_three_pin_oe) == 8'h00;
  endproperty
  a_pu_input: assert property (p_pu_input)
    else $error("pull-up on a driven pin");
  property p_no_sel; !lpc_on && $past(!lpc_on) |-> lpc_pin_sel == 8'h00;
  endproperty
  a_no_sel: assert property (p_no_sel)
    else $error("pin handed to host link while it is off");
  property p_oe_pass; $stable(lpc_pin_sel) |->
    ((port_three_pin_oe ^ $past(lpc_pin_oe)) & lpc_pin_sel) == 8'h00;
  endproperty
  a_oe_pass: assert property (p_oe_pass)
    else $error("owned pin enable not from host logic");
  property p_out_pass; $stable(lpc_pin_sel) |->
    ((port_three_pin_out ^ $past(lpc_pin_out)) & lpc_pin_sel) == 8'h00;
  endproperty
  a_out_pass: assert property (p_out_pass)
    else $error("owned pin level not from host logic");
  property p_in_mask;
    (lpc_pin_in & ~(lpc_pin_sel | $past(lpc_pin_sel))) == 8'h00;
  endproperty
  a_in_mask: assert property (p_in_mask)
    else $error("host link sees a pin it does not own");
  // ----------------------------------------------------------------
  // Second port
  // ----------------------------------------------------------------
  property p_pwm_rst; sw_standby |=> pwm_unit_reset; endproperty
  a_pwm_rst: assert property (p_pwm_rst)
    else $error("pwm not held in reset in software standby");
  property p_p4_oe; !$past(sys_rst) && $stable(port_four_direction) |->
    port_four_pin_oe[5:0] == (port_four_direction[5:0] | $past(periph_pin_oe));
  endproperty
  a_p4_oe: assert property (p_p4_oe)
    else $error("second port enable wrong");
endmodule : gpio_port_chk

bind lpc_shared_gpio_port gpio_port_chk u_chk (.*);

// ==== dv/pin_board_model.sv ====
// Board model: pin levels seen by the first port
`timescale 1ns/1ps
module pin_board_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] port_three_pin_out,
  input  wire logic [7:0] port_three_pin_oe,
  input  wire logic [7:0] port_three_pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] port_three_pin_in
);
  logic [7:0] float_reg = 8'h55;
  // Floating pins wander so a stale level never passes for a read
  always @(posedge core_clk) float_reg <= ~float_reg;
  always_comb port_three_pin_in = (port_three_pin_oe & port_three_pin_out)
    | (~port_three_pin_oe & ext_en & ext_val)
    | (~port_three_pin_oe & ~ext_en & (port_three_pullup_en | float_reg));
endmodule : pin_board_model

// ==== dv/tb_top.sv ====
// Testbench: register, pin and standby checks of the shared GPIO port
`timescale 1ns/1ps
module tb_top;
  import gpio_port_pkg::*;
  logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic hw_standby = 0, sw_standby = 0;
  logic alt_host_interface_enable, avs_waitrequest, pwm_unit_reset;
  addr_t avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, r;
  logic [3:0] avs_byteenable = 4'hF;
  logic [2:0] lpc_channel_enable;
  logic [1:0] pwm_pin_oe = 2'h0;
  logic [5:0] periph_pin_oe = 6'h00;
  port_t port_three_pin_in, port_three_pin_out, port_three_pin_oe;
  port_t port_three_pullup_en, lpc_pin_in, lpc_pin_sel, exp_oe;
  port_t port_four_direction, port_four_pin_oe;
  port_t lpc_pin_out = 8'h5A, lpc_pin_oe = 8'h0F;
  port_t ext_val = 8'h00, ext_en = 8'hFF;
  int fails = 0, checks_done = 0, cycles = 0;
  typedef struct {port_t dir, lat, pcr; logic [3:0] ctl;
                  port_t ext, rd, pu, sel;} row_s;
  row_s rows[6] = '{
    '{8'hFF, 8'hA5, 8'hFF, 4'h0, 8'h3C, 8'hA5, 8'h00, 8'h00},
    '{8'h00, 8'hA5, 8'hF0, 4'h0, 8'h3C, 8'h3C, 8'hF0, 8'h00},
    '{8'h0F, 8'h5A, 8'hFF, 4'h0, 8'hC3, 8'hCA, 8'hF0, 8'h00},
    '{8'h00, 8'h00, 8'hFF, 4'h2, 8'h96, 8'h9A, 8'h00, 8'hFF},
    '{8'h00, 8'h00, 8'hFF, 4'h4, 8'h96, 8'h9A, 8'h00, 8'hFF},
    '{8'h00, 8'h00, 8'hFF, 4'h8, 8'h96, 8'h9A, 8'h00, 8'hFF}};
  addr_t zero_ofs[5] = '{5'h00, 5'h08, 5'h0C, 5'h10, 5'h18};

  lpc_shared_gpio_port dut (.*);
  pin_board_model board (.*);

  always #50 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input addr_t a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (zero_ofs[i]) begin
      bus(1'b0, zero_ofs[i], 32'h0, r);
      chk(r, 32'h0);
    end
    bus(1'b0, OFS_PORT_THREE_LATCH, 32'h0, r);
    chk(r, 32'h0);
    foreach (rows[i]) begin
      // Host link is off while direction changes, so no illegal mix
      bus(1'b1, OFS_HOST_IFACE_CONTROL, 32'h0, r);
      bus(1'b1, OFS_PORT_THREE_DIRECTION, 32'(rows[i].dir), r);
      bus(1'b1, OFS_PORT_THREE_LATCH, 32'(rows[i].lat), r);
      bus(1'b1, OFS_PORT_THREE_PULLUP, 32'(rows[i].pcr), r);
      bus(1'b1, OFS_HOST_IFACE_CONTROL, 32'(rows[i].ctl), r);
      ext_val <= rows[i].ext;
      repeat (4) @(posedge core_clk);
      bus(1'b0, OFS_PORT_THREE_LATCH, 32'h0, r);
      chk(r, 32'(rows[i].rd));
      bus(1'b0, OFS_PORT_THREE_PULLUP, 32'h0, r);
      chk(r, 32'(rows[i].pcr));
      chk(32'(port_three_pullup_en), 32'(rows[i].pu));
      chk(32'(lpc_pin_sel), 32'(rows[i].sel));
      exp_oe = (lpc_pin_oe & rows[i].sel) | (rows[i].dir & ~rows[i].sel);
      chk(32'(port_three_pin_oe), 32'(exp_oe));
      chk(32'(port_three_pin_out & exp_oe), 32'(exp_oe & ((lpc_pin_out &
          rows[i].sel) | (rows[i].lat & ~rows[i].sel))));
    end
    // Byte lane zero off: the write must be dropped
    bus(1'b1, OFS_HOST_IFACE_CONTROL, 32'h0, r);
    bus(1'b1, OFS_PORT_THREE_DIRECTION, 32'hFF, r);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_PORT_THREE_LATCH, 32'hFF, r);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_PORT_THREE_LATCH, 32'h0, r);
    chk(r, 32'h0);
    // Hardware standby overrides the control bits
    bus(1'b1, OFS_PORT_THREE_DIRECTION, 32'h0, r);
    bus(1'b1, OFS_PORT_THREE_PULLUP, 32'hFF, r);
    repeat (2) @(posedge core_clk);
    chk(32'(port_three_pullup_en), 32'hFF);
    hw_standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'(port_three_pullup_en), 32'h0);
    hw_standby <= 1'b0;
    // Software standby drops the pwm enables only
    bus(1'b1, OFS_PORT_FOUR_DIRECTION, 32'h81, r);
    periph_pin_oe <= 6'h06;
    pwm_pin_oe <= 2'h3;
    sw_standby <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'(port_four_pin_oe), 32'h87);
    chk(32'(pwm_unit_reset), 32'h1);
    chk(32'(port_three_pullup_en), 32'hFF);
    sw_standby <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(32'(port_four_pin_oe), 32'hC7);
    chk(32'(port_four_direction), 32'h81);
    // Reset in mid-run clears every configuration register
    bus(1'b1, OFS_PORT_THREE_LATCH, 32'hA5, r);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(32'(port_three_pin_oe), 32'h0);
    chk(32'(port_three_pullup_en), 32'h0);
    chk(32'(port_four_direction), 32'h0);
    bus(1'b1, OFS_PORT_THREE_DIRECTION, 32'hFF, r);
    bus(1'b0, OFS_PORT_THREE_LATCH, 32'h0, r);
    chk(r, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
